// ---- spi_mode_pkg.sv ----
/*
 * constants shared by the serial front end and mode control:
 * word length, bit field positions inside the command word, reset values.
 * assumes nothing of its surroundings; imported whole by the design module.
 */
package spi_mode_pkg;
    // serial word length in bits
    localparam int WORD_BITS = 16;
    // command word layout: [15:14] target select, [13:0] payload
    localparam int CMD_SEL_HI = 15;
    localparam int CMD_SEL_LO = 14;
    // target select codes
    localparam logic [1:0] SEL_SWITCH = 2'h0; // octal switch on/off bits [7:0]
    localparam logic [1:0] SEL_GATE = 2'h1;   // gate bits [5:0], and/or bit 6, pulse gen bit 7
    localparam logic [1:0] SEL_CURRENT = 2'h2; // current drivers bits [1:0], pair mode bits [5:2]
    localparam logic [1:0] SEL_DIAG = 2'h3;   // filter [3:0], threshold [7:4], feedback channel [10:8]
    // field positions
    localparam int GATE_AND_BIT = 6;
    localparam int GATE_PWM_BIT = 7;
    localparam int CUR_PAIR_LO = 2;
    localparam int DIAG_FILT_LO = 0;
    localparam int DIAG_THR_LO = 4;
    localparam int DIAG_CHAN_LO = 8;
    // reset values: all off, or-combined, pulse generators off
    localparam logic [7:0] SWITCH_RST = 8'h00;
    localparam logic [5:0] GATE_RST = 6'h00;
    localparam logic GATE_AND_RST = 1'b0;
    localparam logic GATE_PWM_RST = 1'b0;
    localparam logic [1:0] CUR_RST = 2'h0;
    localparam logic [3:0] PAIR_RST = 4'h0;
    localparam logic [3:0] FILT_RST = 4'h0;
    localparam logic [3:0] THR_RST = 4'h0;
    localparam logic [2:0] CHAN_RST = 3'h0;
endpackage : spi_mode_pkg

// ---- spi_mode_control_front_end.sv ----
/*
 * serial command front end and mode control of an output driver chip.
 * shift logic runs on the master's serial clock; command registers and
 * output gating run on mclk. chip select, enable, override and parallel
 * inputs are pins and are synchronised into mclk. the serial clock may
 * also toggle while chip select is high; those clocks are ignored.
 */
`timescale 1ns/100ps

module spi_mode_control_front_end
    import spi_mode_pkg::*;
#(
    parameter int SYNC_STAGES = 2 // pin synchroniser depth
) (
    input wire logic mclk,                     // system clock, 125 MHz
    input wire logic rst,                      // synchronous reset, active high
    input wire logic sclk,                     // serial clock from master
    input wire logic csN,                      // chip select, active low
    input wire logic serIn,                    // serial data in
    output logic serOut,                       // serial data out
    output logic serOutEnN,                    // serial out enable, low drives
    input wire logic deviceEnable,             // enable pin, high = awake
    input wire logic logicSupplyOk,            // logic supply present
    input wire logic batterySupplyOk,          // battery_supply present
    input wire logic defaultPin,               // override, high = default mode
    input wire logic [5:0] gateParallelCtrlIns, // gate_parallel_ctrl_ins
    input wire logic [3:0] switchParallelIns,  // switch_parallel_ins, for 1,3,5,7
    input wire logic [7:0] switchFault,        // octal switch faults
    input wire logic [5:0] gateFault,          // gate predriver faults
    input wire logic [1:0] currentFault,       // current driver faults
    output logic [7:0] octalSwitch,            // octal_switch on
    output logic currentDriverA,               // current_driver_a on
    output logic currentDriverB,               // current_driver_b on
    output logic [5:0] gatePredriverOuts,      // gate_predriver_outs
    output logic pwmGenEnable,                 // internal pulse generators on
    output logic [3:0] faultFilterSel,         // drain sense filter time code
    output logic [3:0] drainThresholdSel,      // drain_sense_in threshold code
    output logic [2:0] loadResFeedbackChan,    // load_resistance_feedback channel
    output logic sleepMode,                    // device asleep
    output logic defaultMode                   // default mode active
);
    // refuse a synchroniser too short to settle a pin
    if (SYNC_STAGES < 2) begin : gen_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    typedef enum logic [1:0] {
        MODE_SLEEP = 2'h0,
        MODE_NORMAL = 2'h1,
        MODE_DEFAULT = 2'h2
    } mode_e;

    // link domain (sclk)
    logic [WORD_BITS-1:0] shiftIn_q;   // input shift register
    logic [WORD_BITS-1:0] shiftOut_q;  // output shift register
    logic [4:0] bitCnt_q;              // rising clocks seen, saturates
    logic csSeen_q;                    // first rising edge of a frame seen
    logic serOut_q;                    // output bit, changes on falling edge
    logic outLoaded_q;                 // output shifter already started

    // mclk domain
    logic [SYNC_STAGES-1:0] csSync_q;  // chip select synchroniser
    logic [SYNC_STAGES-1:0] enSync_q;  // enable synchroniser
    logic [SYNC_STAGES-1:0] supSync_q; // supplies synchroniser
    logic [SYNC_STAGES-1:0] defSync_q; // override synchroniser
    logic [SYNC_STAGES-1:0] seenSync_q; // frame-clocked flag synchroniser
    logic frameClocked_q;              // current frame saw at least one clock
    logic [5:0] gateSync1_q;           // gate input stage one
    logic [5:0] gateSync2_q;           // gate input stage two
    logic [3:0] swSync1_q;             // switch input stage one
    logic [3:0] swSync2_q;             // switch input stage two
    logic csPrev_q;                    // delayed synchronised select
    logic awakePrev_q;                 // awake last cycle
    logic [WORD_BITS-1:0] status_q;    // fault snapshot for next reply
    logic [7:0] swReg_q;               // switch on bits
    logic [5:0] gateReg_q;             // gate on bits
    logic gateAnd_q;                   // 1 = and combine, 0 = or
    logic gatePwm_q;                   // internal pulse generators
    logic [1:0] curReg_q;              // current driver on bits
    logic [3:0] pairReg_q;             // switch pair mode per input
    logic [3:0] filtReg_q;             // filter time code
    logic [3:0] thrReg_q;              // threshold code
    logic [2:0] chanReg_q;             // feedback channel
    mode_e mode_q;                     // operating mode
    logic awake;                       // enable and supplies present
    logic porReset;                    // reset of command registers
    logic csFall;                      // synchronised select falling
    logic csRise;                      // synchronised select rising
    logic [WORD_BITS-1:0] cmdWord;     // word held by sclk logic
    logic cmdFull;                     // exactly sixteen clocks

    // awake needs enable and both supplies
    assign awake = enSync_q[SYNC_STAGES-1] & supSync_q[SYNC_STAGES-1];
    assign porReset = rst | ~awake | (awake & ~awakePrev_q);
    assign csFall = csPrev_q & ~csSync_q[SYNC_STAGES-1];
    assign csRise = ~csPrev_q & csSync_q[SYNC_STAGES-1];

    // sample msb first on rising clock
    // the word and count survive the rise of select, so mclk can still read
    // them after select has crossed; a clock while deselected is ignored
    always_ff @(posedge sclk) begin
        if (!csN) begin
            if (!csSeen_q) begin
                // first clock of a new frame starts from a clear word and count
                shiftIn_q <= {{(WORD_BITS-1){1'b0}}, serIn};
                bitCnt_q <= 5'h01;
            end else begin
                shiftIn_q <= {shiftIn_q[WORD_BITS-2:0], serIn};
                if (bitCnt_q != 5'h1f) begin
                    bitCnt_q <= bitCnt_q + 5'h01;
                end
            end
        end
    end

    // marks that the frame's first rising edge has passed
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            csSeen_q <= 1'b0;
        end else begin
            csSeen_q <= 1'b1;
        end
    end

    // status shifts msb first, next on falling
    // status_q is stable across the frame: it changes only at a select fall,
    // before the serial clock moves, or when porReset clears it
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            shiftOut_q <= '0;
            outLoaded_q <= 1'b0;
        end else if (!outLoaded_q) begin
            shiftOut_q <= {status_q[WORD_BITS-3:0], 2'b00};
            outLoaded_q <= 1'b1;
        end else begin
            shiftOut_q <= {shiftOut_q[WORD_BITS-2:0], 1'b0};
        end
    end

    // falling edge presents the next bit
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            serOut_q <= 1'b0;
        end else if (!outLoaded_q) begin
            serOut_q <= status_q[WORD_BITS-2];
        end else begin
            serOut_q <= shiftOut_q[WORD_BITS-1];
        end
    end

    // drive only while selected; first bit before any clock
    assign serOut = (!csN && !csSeen_q && !outLoaded_q) ? status_q[WORD_BITS-1] : serOut_q;
    assign serOutEnN = csN;

    // word is stable once select is high, read after synchronising
    assign cmdWord = shiftIn_q;
    // accept exactly sixteen clocks
    // a frame with no clock at all leaves the old count standing, hence the flag
    assign cmdFull = frameClocked_q && (bitCnt_q == 5'(WORD_BITS));

    // pin synchronisers, first stage read only by the second
    always_ff @(posedge mclk) begin
        csSync_q <= {csSync_q[SYNC_STAGES-2:0], csN};
        enSync_q <= {enSync_q[SYNC_STAGES-2:0], deviceEnable};
        supSync_q <= {supSync_q[SYNC_STAGES-2:0], logicSupplyOk & batterySupplyOk};
        defSync_q <= {defSync_q[SYNC_STAGES-2:0], defaultPin};
        seenSync_q <= {seenSync_q[SYNC_STAGES-2:0], csSeen_q};
        gateSync1_q <= gateParallelCtrlIns;
        gateSync2_q <= gateSync1_q;
        swSync1_q <= switchParallelIns;
        swSync2_q <= swSync1_q;
    end

    // edge history of select and awake state
    always_ff @(posedge mclk) begin
        if (rst) begin
            csPrev_q <= 1'b1;
            awakePrev_q <= 1'b0;
        end else begin
            csPrev_q <= csSync_q[SYNC_STAGES-1];
            awakePrev_q <= awake;
        end
    end

    // remember that this frame clocked at least once, so that a frame
    // without clocks cannot commit the word left over from the one before;
    // the set wins over the clear, though frame spacing keeps them apart
    always_ff @(posedge mclk) begin
        if (porReset) begin
            frameClocked_q <= 1'b0;
        end else if (seenSync_q[SYNC_STAGES-1]) begin
            // a clock was seen while selected
            frameClocked_q <= 1'b1;
        end else if (csFall) begin
            // new frame, nothing clocked yet
            frameClocked_q <= 1'b0;
        end
    end

    // snapshot faults at select fall, reply to previous word
    always_ff @(posedge mclk) begin
        if (porReset) begin
            status_q <= '0;
        end else if (csFall) begin
            status_q <= {switchFault, gateFault, currentFault};
        end
    end

    // commit at deselect into the targeted register
    always_ff @(posedge mclk) begin
        if (porReset) begin
            swReg_q <= SWITCH_RST;
            gateReg_q <= GATE_RST;
            gateAnd_q <= GATE_AND_RST;
            gatePwm_q <= GATE_PWM_RST;
            curReg_q <= CUR_RST;
            pairReg_q <= PAIR_RST;
            filtReg_q <= FILT_RST;
            thrReg_q <= THR_RST;
            chanReg_q <= CHAN_RST;
        end else if (csRise && cmdFull) begin
            unique case (cmdWord[CMD_SEL_HI:CMD_SEL_LO])
                SEL_SWITCH: begin
                    swReg_q <= cmdWord[7:0];
                end
                SEL_GATE: begin
                    gateReg_q <= cmdWord[5:0];
                    gateAnd_q <= cmdWord[GATE_AND_BIT];
                    gatePwm_q <= cmdWord[GATE_PWM_BIT];
                end
                SEL_CURRENT: begin
                    curReg_q <= cmdWord[1:0];
                    pairReg_q <= cmdWord[CUR_PAIR_LO +: 4];
                end
                SEL_DIAG: begin
                    filtReg_q <= cmdWord[DIAG_FILT_LO +: 4];
                    thrReg_q <= cmdWord[DIAG_THR_LO +: 4];
                    chanReg_q <= cmdWord[DIAG_CHAN_LO +: 3];
                end
            endcase
        end
    end

    // mode follows pins, default keeps registers
    always_ff @(posedge mclk) begin
        if (rst || !awake) begin
            mode_q <= MODE_SLEEP;
        end else if (defSync_q[SYNC_STAGES-1]) begin
            mode_q <= MODE_DEFAULT;
        end else begin
            mode_q <= MODE_NORMAL;
        end
    end

    // output drive from registers, parallel inputs and mode
    always_ff @(posedge mclk) begin
        if (rst) begin
            octalSwitch <= 8'h00;
            gatePredriverOuts <= 6'h00;
            currentDriverA <= 1'b0;
            currentDriverB <= 1'b0;
        end else begin
            unique case (mode_q)
                MODE_NORMAL: begin
                    // or or and of parallel input with serial bit
                    gatePredriverOuts <= gateAnd_q ? (gateReg_q & gateSync2_q) : (gateReg_q | gateSync2_q);
                    // odd switches follow inputs, pair mode also drives even partner
                    for (int i = 0; i < 4; i++) begin
                        octalSwitch[2*i] <= swReg_q[2*i] | swSync2_q[i];
                        octalSwitch[2*i+1] <= pairReg_q[i] ? (swReg_q[2*i] | swSync2_q[i]) : swReg_q[2*i+1];
                    end
                    currentDriverA <= curReg_q[0];
                    currentDriverB <= curReg_q[1];
                end
                MODE_DEFAULT: begin
                    octalSwitch <= 8'h00;
                    currentDriverA <= 1'b0;
                    currentDriverB <= 1'b0;
                    gatePredriverOuts <= gateSync2_q;
                end
                default: begin
                    // sleep: everything off
                    octalSwitch <= 8'h00;
                    gatePredriverOuts <= 6'h00;
                    currentDriverA <= 1'b0;
                    currentDriverB <= 1'b0;
                end
            endcase
        end
    end

    // pulse generators held off in default mode
    assign pwmGenEnable = gatePwm_q & (mode_q == MODE_NORMAL);
    assign faultFilterSel = filtReg_q;
    assign drainThresholdSel = thrReg_q;
    assign loadResFeedbackChan = chanReg_q;
    assign sleepMode = (mode_q == MODE_SLEEP);
    assign defaultMode = (mode_q == MODE_DEFAULT);

    sequence selRise_s;
        csRise && cmdFull && cmdWord[CMD_SEL_HI:CMD_SEL_LO] == SEL_SWITCH;
    endsequence

    commit_switch_a: assert property (@(posedge mclk) disable iff (porReset)
        selRise_s |=> swReg_q == $past(cmdWord[7:0]))
        else $error("switch word not committed");
    short_word_a: assert property (@(posedge mclk) disable iff (porReset)
        csRise && !cmdFull |=> $stable(swReg_q) && $stable(gateReg_q) && $stable(chanReg_q))
        else $error("short word committed");
    default_off_a: assert property (@(posedge mclk) disable iff (rst)
        mode_q == MODE_DEFAULT |=> octalSwitch == 8'h00 && !currentDriverA && !currentDriverB)
        else $error("outputs on in default mode");
    default_gate_a: assert property (@(posedge mclk) disable iff (rst)
        mode_q == MODE_DEFAULT |=> gatePredriverOuts == $past(gateSync2_q))
        else $error("gates not following inputs");
    default_keep_a: assert property (@(posedge mclk) disable iff (porReset)
        defaultMode && !csRise |=> $stable(gateReg_q) && $stable(swReg_q))
        else $error("registers changed in default");
    or_combine_a: assert property (@(posedge mclk) disable iff (rst)
        mode_q == MODE_NORMAL && !gateAnd_q |=> gatePredriverOuts == ($past(gateReg_q) | $past(gateSync2_q)))
        else $error("or combine wrong");
    sleep_reset_a: assert property (@(posedge mclk) disable iff (rst)
        !awake |=> swReg_q == SWITCH_RST && gateReg_q == GATE_RST && !gateAnd_q)
        else $error("registers kept through sleep");
    out_tristate_a: assert property (@(posedge mclk)
        csN |-> serOutEnN)
        else $error("output driven while deselected");
    status_load_a: assert property (@(posedge mclk) disable iff (porReset)
        csFall |=> status_q == $past({switchFault, gateFault, currentFault}))
        else $error("status not loaded");
    sleep_mode_a: assert property (@(posedge mclk) disable iff (rst)
        !awake |=> sleepMode ##1 octalSwitch == 8'h00)
        else $error("not asleep with enable low");

    sequence gateRise_s;
        csRise && cmdFull && cmdWord[CMD_SEL_HI:CMD_SEL_LO] == SEL_GATE;
    endsequence

    commit_gate_a: assert property (@(posedge mclk) disable iff (porReset)
        gateRise_s |=> gateReg_q == $past(cmdWord[5:0]) && gateAnd_q == $past(cmdWord[GATE_AND_BIT]))
        else $error("gate word not committed");
    and_combine_a: assert property (@(posedge mclk) disable iff (rst)
        mode_q == MODE_NORMAL && gateAnd_q |=> gatePredriverOuts == ($past(gateReg_q) & $past(gateSync2_q)))
        else $error("and combine wrong");
    status_hold_a: assert property (@(posedge mclk) disable iff (porReset)
        !csFall |=> $stable(status_q))
        else $error("status changed outside select fall");
    pair_drive_a: assert property (@(posedge mclk) disable iff (rst)
        mode_q == MODE_NORMAL && pairReg_q[0] |=> octalSwitch[1] == octalSwitch[0])
        else $error("paired switch not following");
endmodule : spi_mode_control_front_end

// ---- spi_host_model.sv ----
/*
 * host master model for the serial link: drives select, clock and data in,
 * samples the device's reply. the clock stands low outside frames, except while junk toggles it.
 * assumes the bench resolves the shared data-out wire and feeds it back here.
 */
`timescale 1ns/100ps
module spi_host_model #(
    parameter real HALF_NS = 24.0 // half period of the 48 ns link clock
) (
    output logic sclk,     // serial clock, still between frames unless junk runs
    output logic csN,      // chip select, active low
    output logic serIn,    // data toward the device
    input wire logic serWire // resolved data-out wire
);
    // idle: deselected, clock low
    initial begin
        sclk = 1'b0;
        serIn = 1'b0;
        // a clean rising edge on select puts the link logic in its idle state
        #1;
        csN = 1'b1;
    end

    task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] reply);
        reply = 16'h0000;
        // odd offset keeps the link out of phase with mclk
        #7.3;
        csN = 1'b0;
        // lead time covers the status snapshot after the select edge
        #80;
        for (int i = 0; i < nbits; i++) begin
            // msb first; surplus bits of a long frame are inverted filler
            serIn = (i < 16) ? word[15-i] : ~serIn;
            #(HALF_NS);
            sclk = 1'b1;
            if (i < 16) begin
                reply[15-i] = serWire;
            end
            #(HALF_NS);
            sclk = 1'b0;
        end
        #(HALF_NS);
        csN = 1'b1;
        // released data line must not keep its last value
        serIn = ~serIn;
        // gap well above the minimum spacing between frames
        #1200;
    endtask : xfer

    // wiggle clock and data while deselected
    task automatic junk(input int n);
        repeat (2 * n) begin
            #(HALF_NS);
            sclk = ~sclk;
            serIn = ~serIn;
        end
    endtask : junk
endmodule : spi_host_model

// ---- spi_mode_control_front_end_tb.sv ----
/*
 * self-checking bench for the serial front end and mode control: random
 * commands through the host model, pin-driven mode changes, sleep and wake.
 * assumes the design package and the host model file are compiled first.
 */
`timescale 1ns/100ps
module spi_mode_control_front_end_tb;
    import spi_mode_pkg::*;
    logic mclk, rst, sclk, csN, serIn, serOut, serOutEnN, serWire;
    logic deviceEnable, logicSupplyOk, batterySupplyOk, defaultPin;
    logic [5:0] gatePar, gateFault, gatePredriverOuts;
    logic [3:0] swPar, faultFilterSel, drainThresholdSel;
    logic [7:0] switchFault, octalSwitch;
    logic [1:0] currentFault;
    logic currentDriverA, currentDriverB, pwmGenEnable, sleepMode, defaultMode;
    logic [2:0] loadResFeedbackChan;
    // expected register contents, kept from the commands sent
    logic [7:0] expSw;
    logic [5:0] expGate;
    logic [3:0] expPair, expFilt, expThr;
    logic [2:0] expChan;
    logic [1:0] expCur;
    logic expAnd, expPwm;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_0038; // fixed start for repeatable runs

    // no pull on the data-out wire: undriven shows as z and never matches
    assign serWire = serOutEnN ? 1'bz : serOut;

    spi_mode_control_front_end spi_mode_control_front_end_i (.mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN),
        .serIn(serIn), .serOut(serOut), .serOutEnN(serOutEnN), .deviceEnable(deviceEnable),
        .logicSupplyOk(logicSupplyOk), .batterySupplyOk(batterySupplyOk), .defaultPin(defaultPin),
        .gateParallelCtrlIns(gatePar), .switchParallelIns(swPar), .switchFault(switchFault),
        .gateFault(gateFault), .currentFault(currentFault), .octalSwitch(octalSwitch),
        .currentDriverA(currentDriverA), .currentDriverB(currentDriverB), .gatePredriverOuts(gatePredriverOuts),
        .pwmGenEnable(pwmGenEnable), .faultFilterSel(faultFilterSel), .drainThresholdSel(drainThresholdSel),
        .loadResFeedbackChan(loadResFeedbackChan), .sleepMode(sleepMode), .defaultMode(defaultMode));

    spi_host_model host_i (.sclk(sclk), .csN(csN), .serIn(serIn), .serWire(serWire));

    // 125 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // hang guard: the whole run needs far fewer cycles than this
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs

    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp

    task automatic porState();
        expSw = SWITCH_RST;
        expGate = GATE_RST;
        expAnd = GATE_AND_RST;
        expPwm = GATE_PWM_RST;
        expCur = CUR_RST;
        expPair = PAIR_RST;
        {expFilt, expThr, expChan} = {FILT_RST, THR_RST, CHAN_RST};
    endtask : porState

    // committed word updates the selected registers
    task automatic apply(input logic [15:0] w);
        case (w[CMD_SEL_HI:CMD_SEL_LO])
            SEL_SWITCH: expSw = w[7:0];
            SEL_GATE: {expPwm, expAnd, expGate} = w[GATE_PWM_BIT:0];
            SEL_CURRENT: {expPair, expCur} = w[CUR_PAIR_LO+3:0];
            default: {expChan, expThr, expFilt} = w[DIAG_CHAN_LO+2:0];
        endcase
    endtask : apply

    task automatic settle();
        repeat (10) @(posedge mclk);
        #1;
    endtask : settle

    task automatic checkOuts();
        logic [7:0] eo;
        logic [5:0] eg;
        logic awake;
        awake = deviceEnable & logicSupplyOk & batterySupplyOk;
        eg = expAnd ? (expGate & gatePar) : (expGate | gatePar);
        for (int i = 0; i < 4; i++) begin
            eo[2*i] = expSw[2*i] | swPar[i];
            eo[2*i+1] = expPair[i] ? eo[2*i] : expSw[2*i+1];
        end
        // default mode: switches off, gates straight from their pins
        if (defaultPin) begin
            eo = 8'h00;
            eg = gatePar;
        end
        // asleep: everything off
        if (!awake) begin
            eo = 8'h00;
            eg = 6'h00;
        end
        cmp("octalSwitch", {8'h00, eo}, {8'h00, octalSwitch});
        cmp("gates", {10'h000, eg}, {10'h000, gatePredriverOuts});
        cmp("current", {14'h0000, (awake & !defaultPin) ? expCur : 2'h0},
            {14'h0000, currentDriverB, currentDriverA});
        cmp("pwmGen", {15'h0000, expPwm & awake & !defaultPin}, {15'h0000, pwmGenEnable});
        cmp("diag", {5'h00, expChan, expThr, expFilt},
            {5'h00, loadResFeedbackChan, drainThresholdSel, faultFilterSel});
        cmp("mode", {14'h0000, !awake, awake & defaultPin}, {14'h0000, sleepMode, defaultMode});
    endtask : checkOuts

    task automatic frame(input logic [15:0] w, input int n);
        logic [15:0] reply;
        logic [15:0] mask;
        // a short frame never shifts the low reply bits, which stay zero
        mask = (n >= WORD_BITS) ? 16'hffff : ~(16'hffff >> n);
        host_i.xfer(w, n, reply);
        cmp("reply", {switchFault, gateFault, currentFault} & mask, reply);
        cmp("serOutEnN", 16'h0001, {15'h0000, serOutEnN});
        if (n == WORD_BITS) begin
            apply(w);
        end
        checkOuts();
    endtask : frame

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        rst = 1'b1;
        {deviceEnable, logicSupplyOk, batterySupplyOk, defaultPin} = 4'h6;
        {gatePar, swPar, switchFault, gateFault, currentFault} = 26'h0000000;
        porState();
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        settle();
        checkOuts();
        @(posedge mclk);
        deviceEnable <= 1'b1;
        settle();
        checkOuts();
        // corner: every gate bit with and-combining, then back to back
        frame(16'h40ff, WORD_BITS);
        frame(16'h803c, WORD_BITS);
        for (int k = 0; k < 24; k++) begin
            seed = xs(seed);
            @(posedge mclk);
            {switchFault, gateFault, currentFault} <= seed[31:16];
            {gatePar, swPar} <= seed[9:0];
            settle();
            seed = xs(seed);
            frame({k[1:0], seed[13:0]}, WORD_BITS);
        end
        // short and long frames are discarded
        frame(16'h00a5, 15);
        frame(16'h005a, 17);
        host_i.junk(10);
        settle();
        checkOuts();
        cmp("idleEnN", 16'h0001, {15'h0000, serOutEnN});
        // default mode and return to programmed state
        @(posedge mclk);
        defaultPin <= 1'b1;
        settle();
        checkOuts();
        @(posedge mclk);
        defaultPin <= 1'b0;
        settle();
        checkOuts();
        // each of the three wake conditions: drop, check sleep, wake with reset
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            frame({k[1:0], seed[13:0]}, WORD_BITS);
            @(posedge mclk);
            {deviceEnable, logicSupplyOk, batterySupplyOk} <= 3'h7 ^ (3'h4 >> k);
            settle();
            porState();
            checkOuts();
            @(posedge mclk);
            {deviceEnable, logicSupplyOk, batterySupplyOk} <= 3'h7;
            settle();
            checkOuts();
        end
        conclude();
    end
endmodule : spi_mode_control_front_end_tb
